// ### logic/alrt_regs.sv
// alert limit, mask-enable and identification registers with alert pin
// Functional notes
// - compare selected measurement against stored alert limit value
// - alert limit register read/write, sixteen bits, zero at reset
// - maker identification register returns fixed code, writes ignored
// - die identification upper twelve bits return fixed device code
// - die identification lower four bits return fixed revision code
// - alert pin follows one of five limit functions or conversion done
// - several select bits set: only the highest one is compared
// - latch mode holds alert until mask read; transparent follows fault
// - sense bit one gives active-high alert, zero active-low
`timescale 1ns/10ps
`include "alrt_defines.svh"

module alrt_regs
	import alrt_pkg::*;
#(
	parameter logic [15:0] MAKER_CODE = `ALRT_MAKER_CODE,
	parameter logic [11:0] DEVICE_CODE = `ALRT_DEVICE_CODE,
	parameter logic [3:0] REVISION_CODE = `ALRT_REVISION_CODE
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// register access from the serial host controller
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_stb,
	input wire logic reg_rd_stb,
	input wire alrt_word_t reg_wdata,
	output alrt_word_t reg_rdata,
	output logic reg_rd_valid,
	// conversion engine
	input wire alrt_word_t shunt_value,
	input wire alrt_word_t bus_value,
	input wire alrt_word_t power_value,
	input wire logic meas_done,
	input wire logic math_overflow,
	input wire logic cfg_write,
	// open-drain alert pin
	output logic alert_o,
	output logic alert_oe
);

	alrt_word_t alert_threshold;
	logic [5:0] mask_sel;
	logic alert_sense_select;
	logic alert_latch_select;
	logic alert_source_flag;
	logic conversion_done_flag;
	alrt_func_t cmp_func;
	logic cmp_hit;
	logic wr_thr, wr_mask, rd_mask;
	logic fault_set, conv_set;
	logic alert_active;
	alrt_word_t mask_word;
	alrt_word_t next_rdata;

	function automatic logic hit_addr(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	assign wr_thr = reg_wr_stb && hit_addr(reg_addr, `ALRT_OFS_THRESHOLD);
	assign wr_mask = reg_wr_stb && hit_addr(reg_addr, `ALRT_OFS_MASK_EN);
	assign rd_mask = reg_rd_stb && hit_addr(reg_addr, `ALRT_OFS_MASK_EN);

	alrt_cmp u_cmp (
		.sel(mask_sel[5:1]),
		.alert_limit_value(alert_threshold),
		.shunt_value(shunt_value),
		.bus_value(bus_value),
		.power_value(power_value),
		.func(cmp_func),
		.hit(cmp_hit)
	);

	// the limit is only judged on fresh results, against the old value if it is rewritten in that cycle
	assign fault_set = meas_done && cmp_hit;
	assign conv_set = meas_done;

	// threshold register; the host programs it before selecting a function
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			alert_threshold <= `ALRT_THRESHOLD_RST;
		end else if (wr_thr) begin
			alert_threshold <= reg_wdata;
		end
	end

	// mask-enable control bits
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mask_sel <= 6'h00;
			alert_sense_select <= 1'b0;
			alert_latch_select <= 1'b0;
		end else if (wr_mask) begin
			mask_sel <= reg_wdata[`ALRT_BIT_SHUNT_OVER:`ALRT_BIT_CONV_ALERT];
			alert_sense_select <= reg_wdata[`ALRT_BIT_SENSE];
			alert_latch_select <= reg_wdata[`ALRT_BIT_LATCH];
		end
	end

	// alert source flag: a fault in the clearing cycle wins over the clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			alert_source_flag <= 1'b0;
		end else if (fault_set) begin
			alert_source_flag <= 1'b1;
		end else if (alert_latch_select && rd_mask) begin
			alert_source_flag <= 1'b0;
		end else if (!alert_latch_select && meas_done) begin
			alert_source_flag <= 1'b0;
		end
	end

	// conversion done flag: cleared by mask read or configuration write
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			conversion_done_flag <= 1'b0;
		end else if (conv_set) begin
			conversion_done_flag <= 1'b1;
		end else if (rd_mask || cfg_write) begin
			conversion_done_flag <= 1'b0;
		end
	end

	// limit function or conversion notice may drive the pin
	assign alert_active = alert_source_flag
		|| (mask_sel[0] && conversion_done_flag);

	// open collector: the pin is pulled low when the level must be low
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			alert_oe <= 1'b0;
			alert_o <= 1'b0;
		end else begin
			alert_oe <= alert_active ^ alert_sense_select;
			alert_o <= 1'b0;
		end
	end

	assign mask_word = {mask_sel, 5'h00, alert_source_flag,
		conversion_done_flag, math_overflow, alert_sense_select,
		alert_latch_select};

	// read data returns the value before any clear of the same cycle
	always_comb begin
		case (reg_addr)
			`ALRT_OFS_MASK_EN: begin
				next_rdata = mask_word;
			end
			`ALRT_OFS_THRESHOLD: begin
				next_rdata = alert_threshold;
			end
			`ALRT_OFS_MAKER: begin
				next_rdata = MAKER_CODE;
			end
			`ALRT_OFS_DIE: begin
				next_rdata = {DEVICE_CODE, REVISION_CODE};
			end
			default: begin
				next_rdata = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd_stb) begin
			reg_rdata <= next_rdata;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_stb;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_fault;
		meas_done && cmp_hit;
	endsequence

	sequence s_quiet_conv;
		meas_done && !cmp_hit && !alert_latch_select;
	endsequence

	// one quiet cycle between write and read, as a strobe host spaces them
	a_limit_write: assert property (
		wr_thr ##1 !reg_wr_stb
		##1 (reg_rd_stb && hit_addr(reg_addr, `ALRT_OFS_THRESHOLD))
		|=> reg_rdata == $past(reg_wdata, 3))
		else $error("threshold readback differs from write");

	a_maker_read: assert property (
		reg_rd_stb && hit_addr(reg_addr, `ALRT_OFS_MAKER)
		|=> reg_rd_valid && reg_rdata == MAKER_CODE)
		else $error("maker code read wrong");

	a_die_read: assert property (
		reg_rd_stb && hit_addr(reg_addr, `ALRT_OFS_DIE)
		|=> reg_rdata[15:4] == DEVICE_CODE && reg_rdata[3:0] == REVISION_CODE)
		else $error("die identification read wrong");

	a_fault_pin: assert property (
		s_fault ##0 !alert_sense_select && !wr_mask
		|=> ##1 alert_oe)
		else $error("fault did not pull alert pin");

	a_latch_hold: assert property (
		alert_source_flag && alert_latch_select && !rd_mask && !wr_mask
		|=> alert_source_flag)
		else $error("latched alert flag dropped without read");

	a_transp_clear: assert property (
		s_quiet_conv |=> !alert_source_flag)
		else $error("transparent alert flag stayed set");

	a_top_select: assert property (
		mask_sel[5] |-> cmp_func == ALRT_FN_SHUNT_OVER)
		else $error("highest select bit not given priority");

	a_shunt_signed: assert property (
		cmp_func == ALRT_FN_SHUNT_OVER && shunt_value[15]
		&& !alert_threshold[15] |-> !cmp_hit)
		else $error("negative shunt judged above positive limit");

	a_conv_alert: assert property (
		conversion_done_flag && mask_sel[0] && !alert_sense_select
		|=> alert_oe)
		else $error("conversion notice did not drive alert");

	a_idle_high_sense: assert property (
		!alert_active && alert_sense_select ##1 !wr_mask |-> alert_oe)
		else $error("idle active-high alert not held low");

endmodule

// ### logic/alrt_defines.svh
// register offsets, field positions, reset values of the alert register bank
`ifndef ALRT_DEFINES_SVH
`define ALRT_DEFINES_SVH

`define ALRT_OFS_MASK_EN 8'h06
`define ALRT_OFS_THRESHOLD 8'h07
`define ALRT_OFS_MAKER 8'hFE
`define ALRT_OFS_DIE 8'hFF

`define ALRT_THRESHOLD_RST 16'h0000
`define ALRT_MASK_EN_RST 16'h0000

`define ALRT_BIT_SHUNT_OVER 15
`define ALRT_BIT_SHUNT_UNDER 14
`define ALRT_BIT_BUS_OVER 13
`define ALRT_BIT_BUS_UNDER 12
`define ALRT_BIT_POWER_OVER 11
`define ALRT_BIT_CONV_ALERT 10
`define ALRT_BIT_SRC_FLAG 4
`define ALRT_BIT_CONV_FLAG 3
`define ALRT_BIT_OVF_FLAG 2
`define ALRT_BIT_SENSE 1
`define ALRT_BIT_LATCH 0

`define ALRT_DEVICE_FIELD_MSB 15
`define ALRT_DEVICE_FIELD_LSB 4
`define ALRT_REVISION_FIELD_MSB 3
`define ALRT_REVISION_FIELD_LSB 0

// identity codes: arbitrary neutral values
`define ALRT_MAKER_CODE 16'hA5C3
`define ALRT_DEVICE_CODE 12'h3C1
`define ALRT_REVISION_CODE 4'h2

`endif

// ### logic/alrt_pkg.sv
// types shared by the alert register bank
package alrt_pkg;

	typedef logic [15:0] alrt_word_t;

	typedef enum {
		ALRT_FN_NONE,
		ALRT_FN_SHUNT_OVER,
		ALRT_FN_SHUNT_UNDER,
		ALRT_FN_BUS_OVER,
		ALRT_FN_BUS_UNDER,
		ALRT_FN_POWER_OVER
	} alrt_func_t;

endpackage

// ### logic/alrt_cmp.sv
// limit comparator: picks the highest selected function and compares
`timescale 1ns/10ps
`include "alrt_defines.svh"

module alrt_cmp
	import alrt_pkg::*;
(
	// selection and limit
	input wire logic [4:0] sel,
	input wire alrt_word_t alert_limit_value,
	// measurements
	input wire alrt_word_t shunt_value,
	input wire alrt_word_t bus_value,
	input wire alrt_word_t power_value,
	// result
	output alrt_func_t func,
	output logic hit
);

	// sel[4] is the top select bit, so it is tested first
	function automatic alrt_func_t pick(input logic [4:0] s);
		if (s[4]) begin
			return ALRT_FN_SHUNT_OVER;
		end else if (s[3]) begin
			return ALRT_FN_SHUNT_UNDER;
		end else if (s[2]) begin
			return ALRT_FN_BUS_OVER;
		end else if (s[1]) begin
			return ALRT_FN_BUS_UNDER;
		end else if (s[0]) begin
			return ALRT_FN_POWER_OVER;
		end else begin
			return ALRT_FN_NONE;
		end
	endfunction

	always_comb begin
		func = pick(sel);
		// shunt is two's complement, bus and power are unsigned
		case (func)
			ALRT_FN_SHUNT_OVER: begin
				hit = $signed(shunt_value) > $signed(alert_limit_value);
			end
			ALRT_FN_SHUNT_UNDER: begin
				hit = $signed(shunt_value) < $signed(alert_limit_value);
			end
			ALRT_FN_BUS_OVER: begin
				hit = bus_value > alert_limit_value;
			end
			ALRT_FN_BUS_UNDER: begin
				hit = bus_value < alert_limit_value;
			end
			ALRT_FN_POWER_OVER: begin
				hit = power_value > alert_limit_value;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

endmodule

// ### test/alrt_host.sv
// host controller model for the register strobe port
`timescale 1ns/10ps
module alrt_host
	import alrt_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// register port
	output logic [7:0] reg_addr,
	output logic reg_wr_stb,
	output logic reg_rd_stb,
	output alrt_word_t reg_wdata,
	input wire alrt_word_t reg_rdata,
	input wire logic reg_rd_valid
);
	initial begin
		reg_addr = 8'h00;
		reg_wr_stb = 1'b0;
		reg_rd_stb = 1'b0;
		reg_wdata = 16'h0000;
	end
	// select and threshold writes go through here
	task automatic wr(input logic [7:0] a, input alrt_word_t d);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr_stb = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_wr_stb = 1'b0;
		// stale data flipped so nothing leans on it
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output alrt_word_t d,
		output logic v);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_rd_stb = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_rd_stb = 1'b0;
		d = reg_rdata;
		v = reg_rd_valid;
	endtask
endmodule

// ### test/test_alrt_regs.sv
// self-checking bench for the alert register bank
`timescale 1ns/10ps
`include "alrt_defines.svh"
module test_alrt_regs
	import alrt_pkg::*;
;
	logic ref_clk, rst, reg_wr_stb, reg_rd_stb, reg_rd_valid;
	logic meas_done, math_overflow, cfg_write, alert_o, alert_oe;
	logic [7:0] reg_addr;
	alrt_word_t reg_wdata, reg_rdata, shunt_value, bus_value, power_value;
	int mismatches = 0;
	int cmp_count = 0;

	alrt_regs u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rd_valid(reg_rd_valid), .shunt_value(shunt_value),
		.bus_value(bus_value), .power_value(power_value),
		.meas_done(meas_done), .math_overflow(math_overflow),
		.cfg_write(cfg_write), .alert_o(alert_o), .alert_oe(alert_oe));
	alrt_host u_host (.ref_clk(ref_clk), .reg_addr(reg_addr),
		.reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rd_valid(reg_rd_valid));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic chk(input alrt_word_t got, input alrt_word_t exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [7:0] a, input alrt_word_t exp);
		alrt_word_t d;
		logic v;
		u_host.rd(a, d, v);
		chk({15'h0000, v}, 16'h0001);
		chk(d, exp);
	endtask
	// pin is checked two edges after the conversion pulse
	task automatic ms(input alrt_word_t s, b, p, input logic exp);
		@(posedge ref_clk);
		#1;
		shunt_value = s;
		bus_value = b;
		power_value = p;
		meas_done = 1'b1;
		@(posedge ref_clk);
		#1;
		meas_done = 1'b0;
		@(posedge ref_clk);
		#1;
		chk({15'h0000, alert_oe}, {15'h0000, exp});
		chk({15'h0000, alert_o}, 16'h0000);
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (3000) @(posedge ref_clk);
		mismatches++;
		test_done();
	end

	initial begin
		rst = 1'b1;
		shunt_value = 16'h0000;
		bus_value = 16'h0000;
		power_value = 16'h0000;
		meas_done = 1'b0;
		math_overflow = 1'b0;
		cfg_write = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		rc(`ALRT_OFS_THRESHOLD, `ALRT_THRESHOLD_RST);
		u_host.wr(`ALRT_OFS_MAKER, 16'hFFFF);
		u_host.wr(`ALRT_OFS_DIE, 16'h0000);
		rc(`ALRT_OFS_MAKER, `ALRT_MAKER_CODE);
		rc(`ALRT_OFS_DIE, {`ALRT_DEVICE_CODE, `ALRT_REVISION_CODE});
		rc(8'h10, 16'h0000);
		u_host.wr(`ALRT_OFS_THRESHOLD, 16'hBEEF);
		rc(`ALRT_OFS_THRESHOLD, 16'hBEEF);
		u_host.wr(`ALRT_OFS_THRESHOLD, 16'h0010);
		// transparent, active low, shunt over
		u_host.wr(`ALRT_OFS_MASK_EN, 16'h8000);
		ms(16'h0020, 16'h0000, 16'h0000, 1'b1);
		ms(16'hFFF0, 16'h0000, 16'h0000, 1'b0);
		u_host.wr(`ALRT_OFS_MASK_EN, 16'h4000);
		ms(16'h8000, 16'h0000, 16'h0000, 1'b1);
		// bus under would fire, but shunt over outranks it
		u_host.wr(`ALRT_OFS_MASK_EN, 16'h9000);
		ms(16'h0000, 16'h0000, 16'h0000, 1'b0);
		u_host.wr(`ALRT_OFS_MASK_EN, 16'h0800);
		ms(16'h0000, 16'h0000, 16'h0020, 1'b1);
		u_host.wr(`ALRT_OFS_MASK_EN, 16'h1000);
		ms(16'h0000, 16'h0000, 16'h0000, 1'b1);
		// latch mode, bus over
		u_host.wr(`ALRT_OFS_MASK_EN, 16'h2001);
		ms(16'h0000, 16'h0020, 16'h0000, 1'b1);
		ms(16'h0000, 16'h0000, 16'h0000, 1'b1);
		rc(`ALRT_OFS_MASK_EN, 16'h2019);
		// the pin follows the cleared flag one edge later
		@(posedge ref_clk);
		#1;
		chk({15'h0000, alert_oe}, 16'h0000);
		// active-high sense inverts the pin
		u_host.wr(`ALRT_OFS_MASK_EN, 16'h2002);
		ms(16'h0000, 16'h0000, 16'h0000, 1'b1);
		ms(16'h0000, 16'h0020, 16'h0000, 1'b0);
		// conversion-done alert
		u_host.wr(`ALRT_OFS_MASK_EN, 16'h0400);
		ms(16'h0000, 16'h0000, 16'h0000, 1'b1);
		rc(`ALRT_OFS_MASK_EN, 16'h0408);
		@(posedge ref_clk);
		#1;
		chk({15'h0000, alert_oe}, 16'h0000);
		// configuration write clears the ready flag; overflow shows live
		ms(16'h0000, 16'h0000, 16'h0000, 1'b1);
		cfg_write = 1'b1;
		math_overflow = 1'b1;
		@(posedge ref_clk);
		#1;
		cfg_write = 1'b0;
		@(posedge ref_clk);
		#1;
		chk({15'h0000, alert_oe}, 16'h0000);
		rc(`ALRT_OFS_MASK_EN, 16'h0404);
		test_done();
	end
endmodule
